// ==== cxs_pkg.sv ====
package cxs_pkg;
  // register file map
  localparam logic [7:0] PTR0_ADDR = 8'hd6;
  localparam logic [7:0] PTR1_ADDR = 8'hd7;
  localparam logic [7:0] PTR0_RST = 8'h00;
  localparam logic [7:0] PTR1_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // flag bit positions
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  // execution steps and instruction lengths in cycles
  localparam logic [2:0] STEP_SRC_PTR = 3'h1;
  localparam logic [2:0] STEP_DST_PTR = 3'h2;
  localparam logic [2:0] STEP_SRC_RD = 3'h3;
  localparam logic [2:0] STEP_EXEC = 3'h4;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;

  typedef enum logic [3:0] {
    idle_op,
    carry_set_op,
    arith_right_shift_op,
    pointer_load_op,
    stop_op,
    sub_op,
    swap_op,
    inverted_mask_test_op
  } cxs_op_t;

  typedef struct packed {
    cxs_op_t op;
    logic dst_ind;
    logic src_ind;
    logic src_imm;
    logic wide;
    logic [7:0] dst;
    logic [7:0] src;
  } cxs_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic we;
    logic [7:0] wdata;
  } cxs_rf_req_t;
endpackage

// ==== cxs_exec.sv ====
module cxs_exec (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic cmd_valid, // decoder offers command
  output logic cmd_ready, // block idle
  input cxs_pkg::cxs_cmd_t cmd, // decoded instruction
  output logic done, // instruction finished
  output cxs_pkg::cxs_rf_req_t rf_req, // register file access
  input wire logic [7:0] rf_rdata, // register file read data
  input wire logic external_reset_pin_n, // reset pin
  input wire logic ext_irq, // external interrupt pin
  output logic [7:0] flags, // flag register
  output logic [7:0] window_pointer_zero, // pointer zero
  output logic [7:0] window_pointer_one, // pointer one
  output logic cpu_clk_en, // processor clock run
  output logic sys_clk_en, // system clock run
  output logic stopped // stop mode
);

  typedef enum logic [1:0] {md_idle, md_run, md_stop} cxs_mode_t;

  typedef struct packed {
    cxs_mode_t mode;
    logic [2:0] cnt;
    logic [2:0] target;
    cxs_pkg::cxs_cmd_t cmd;
    logic [7:0] dst_adr;
    logic [7:0] src_adr;
    logic [7:0] src_val;
    logic [7:0] flags;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic done;
    logic [2:0] rst_s;
    logic [2:0] irq_s;
    logic rst_f;
    logic irq_f;
  } cxs_state_t;

  cxs_state_t s_reg, s_next;
  logic [7:0] rd;
  logic [7:0] res;
  logic wr;
  logic borrow;
  logic exec;
  logic [7:0] adr;

  function automatic logic [7:0] zs_flags(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[cxs_pkg::FLG_Z] = (r == 8'h00);
    o[cxs_pkg::FLG_S] = r[7];
    return o;
  endfunction

  function automatic logic two_op(input cxs_pkg::cxs_op_t op);
    return (op == cxs_pkg::sub_op) || (op == cxs_pkg::inverted_mask_test_op);
  endfunction

  assign exec = (s_reg.mode == md_run) && (s_reg.cnt == cxs_pkg::STEP_EXEC);

  ////////////////////////////////////////////////////////////////
  // register file address and read mux
  always_comb begin
    adr = 8'h00;
    case (s_reg.cnt)
      cxs_pkg::STEP_SRC_PTR: adr = s_reg.src_adr;
      cxs_pkg::STEP_DST_PTR: adr = s_reg.dst_adr;
      cxs_pkg::STEP_SRC_RD: adr = s_reg.src_adr;
      cxs_pkg::STEP_EXEC: adr = s_reg.dst_adr;
      default: adr = 8'h00;
    endcase
    if (adr == cxs_pkg::PTR0_ADDR) begin
      rd = s_reg.ptr0;
    end else if (adr == cxs_pkg::PTR1_ADDR) begin
      rd = s_reg.ptr1;
    end else begin
      rd = rf_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // execution
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    res = 8'h00;
    wr = 1'b0;
    borrow = 1'b0;
    rf_req.addr = adr;
    rf_req.we = 1'b0;
    rf_req.wdata = 8'h00;
    // pin synchronisers, change counts when stages two and three agree
    s_next.rst_s = {s_reg.rst_s[1:0], external_reset_pin_n};
    s_next.irq_s = {s_reg.irq_s[1:0], ext_irq};
    if (s_reg.rst_s[1] == s_reg.rst_s[2]) begin
      s_next.rst_f = s_reg.rst_s[2];
    end
    if (s_reg.irq_s[1] == s_reg.irq_s[2]) begin
      s_next.irq_f = s_reg.irq_s[2];
    end
    case (s_reg.mode)
      md_idle: begin
        if (cmd_valid) begin
          s_next.cmd = cmd;
          s_next.dst_adr = cmd.dst;
          s_next.src_adr = cmd.src;
          s_next.src_val = cmd.src;
          s_next.cnt = cxs_pkg::STEP_SRC_PTR;
          s_next.target = (two_op(cmd.op) && (cmd.wide || cmd.src_ind)) ?
                          cxs_pkg::CYC_LONG : cxs_pkg::CYC_SHORT;
          s_next.mode = md_run;
        end
      end
      md_run: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        case (s_reg.cnt)
          cxs_pkg::STEP_SRC_PTR: begin
            if (s_reg.cmd.src_ind && !s_reg.cmd.src_imm) begin
              s_next.src_adr = rd;
            end
          end
          cxs_pkg::STEP_DST_PTR: begin
            if (s_reg.cmd.dst_ind) begin
              s_next.dst_adr = rd;
            end
          end
          cxs_pkg::STEP_SRC_RD: begin
            if (!s_reg.cmd.src_imm) begin
              s_next.src_val = rd;
            end
          end
          cxs_pkg::STEP_EXEC: begin
            case (s_reg.cmd.op)
              cxs_pkg::carry_set_op: begin
                s_next.flags[cxs_pkg::FLG_C] = 1'b1;
              end
              cxs_pkg::arith_right_shift_op: begin
                res = {rd[7], rd[7:1]};
                wr = 1'b1;
                s_next.flags = zs_flags(s_reg.flags, res);
                s_next.flags[cxs_pkg::FLG_C] = rd[0];
                s_next.flags[cxs_pkg::FLG_V] = 1'b0;
              end
              cxs_pkg::pointer_load_op: begin
                case (s_reg.src_val[1:0])
                  2'b10: s_next.ptr0[7:3] = s_reg.src_val[7:3];
                  2'b01: s_next.ptr1[7:3] = s_reg.src_val[7:3];
                  2'b00: begin
                    s_next.ptr0[7:3] = {s_reg.src_val[7:4], 1'b0};
                    s_next.ptr1[7:3] = {s_reg.src_val[7:4], 1'b1};
                  end
                  default: s_next.ptr0 = s_reg.ptr0;
                endcase
              end
              cxs_pkg::sub_op: begin
                {borrow, res} = {1'b0, rd} - {1'b0, s_reg.src_val};
                wr = 1'b1;
                s_next.flags = zs_flags(s_reg.flags, res);
                s_next.flags[cxs_pkg::FLG_C] = borrow;
                s_next.flags[cxs_pkg::FLG_V] = (rd[7] != s_reg.src_val[7]) &&
                                               (res[7] == s_reg.src_val[7]);
                s_next.flags[cxs_pkg::FLG_D] = 1'b1;
                s_next.flags[cxs_pkg::FLG_H] = (rd[3:0] < s_reg.src_val[3:0]);
              end
              cxs_pkg::swap_op: begin
                res = {rd[3:0], rd[7:4]};
                wr = 1'b1;
                s_next.flags = zs_flags(s_reg.flags, res);
              end
              cxs_pkg::inverted_mask_test_op: begin
                res = ~rd & s_reg.src_val;
                s_next.flags = zs_flags(s_reg.flags, res);
                s_next.flags[cxs_pkg::FLG_V] = 1'b0;
              end
              default: res = 8'h00;
            endcase
            if (wr) begin
              if (s_reg.dst_adr == cxs_pkg::PTR0_ADDR) begin
                s_next.ptr0 = res;
              end else if (s_reg.dst_adr == cxs_pkg::PTR1_ADDR) begin
                s_next.ptr1 = res;
              end else begin
                rf_req.we = 1'b1;
                rf_req.wdata = res;
              end
            end
          end
          default: res = 8'h00;
        endcase
        if (s_reg.cnt == s_reg.target) begin
          s_next.cnt = 3'h0;
          if (s_reg.cmd.op == cxs_pkg::stop_op) begin
            s_next.mode = md_stop;
          end else begin
            s_next.mode = md_idle;
            s_next.done = 1'b1;
          end
        end
      end
      md_stop: begin
        // nothing but the pins is looked at; state is held
        if (!s_reg.rst_f || s_reg.irq_f) begin
          s_next.mode = md_idle;
          s_next.done = 1'b1;
        end
      end
      default: s_next.mode = md_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.mode <= md_idle;
      s_reg.flags <= cxs_pkg::FLAGS_RST;
      s_reg.ptr0 <= cxs_pkg::PTR0_RST;
      s_reg.ptr1 <= cxs_pkg::PTR1_RST;
      s_reg.rst_s <= 3'h7;
      s_reg.rst_f <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready = (s_reg.mode == md_idle);
  assign done = s_reg.done;
  assign flags = s_reg.flags;
  assign window_pointer_zero = s_reg.ptr0;
  assign window_pointer_one = s_reg.ptr1;
  assign stopped = (s_reg.mode == md_stop);
  assign cpu_clk_en = !stopped;
  assign sys_clk_en = !stopped;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_short_accept;
    cmd_ready && cmd_valid && !two_op(cmd.op) && (cmd.op != cxs_pkg::stop_op);
  endsequence
  sequence s_dst_fetch;
    s_reg.mode == md_run && s_reg.cnt == cxs_pkg::STEP_DST_PTR && s_reg.cmd.dst_ind;
  endsequence

  a_carry_set_flag: assert property (
    s_short_accept ##0 cmd.op == cxs_pkg::carry_set_op |->
    !done [*5] ##1 (done && flags[cxs_pkg::FLG_C] && flags[6:0] == $past(flags[6:0], 5)))
    else $error("carry set wrong");
  a_shift_value: assert property (
    exec && s_reg.cmd.op == cxs_pkg::arith_right_shift_op && rf_req.we |->
    rf_req.wdata == {rd[7], rd[7:1]})
    else $error("shift result wrong");
  a_shift_flags: assert property (
    exec && s_reg.cmd.op == cxs_pkg::arith_right_shift_op |=>
    flags[cxs_pkg::FLG_C] == $past(rd[0]) && !flags[cxs_pkg::FLG_V] &&
    flags[3:0] == $past(flags[3:0]))
    else $error("shift flags wrong");
  a_ptr_one: assert property (
    exec && s_reg.cmd.op == cxs_pkg::pointer_load_op && s_reg.src_val[1:0] == 2'b01 |=>
    window_pointer_one[7:3] == $past(s_reg.src_val[7:3]) && $stable(window_pointer_zero))
    else $error("pointer one load wrong");
  a_ptr_both: assert property (
    exec && s_reg.cmd.op == cxs_pkg::pointer_load_op && s_reg.src_val[1:0] == 2'b00 |=>
    window_pointer_zero[7:3] == {$past(s_reg.src_val[7:4]), 1'b0} &&
    window_pointer_one[7:3] == {$past(s_reg.src_val[7:4]), 1'b1})
    else $error("pointer pair load wrong");
  a_ptr_flags: assert property (
    exec && s_reg.cmd.op == cxs_pkg::pointer_load_op |=> $stable(flags))
    else $error("pointer load touched flags");
  a_stop_clocks: assert property (
    s_reg.mode == md_run && s_reg.cnt == s_reg.target && s_reg.cmd.op == cxs_pkg::stop_op |=>
    !cpu_clk_en && !sys_clk_en && !done)
    else $error("stop did not gate clocks");
  a_stop_retain: assert property (
    stopped |=> $stable(flags) && $stable(window_pointer_zero) && $stable(window_pointer_one))
    else $error("state lost in stop");
  a_stop_wake: assert property (
    stopped |=> (stopped == ($past(s_reg.rst_f) && !$past(s_reg.irq_f))))
    else $error("stop exit wrong");
  a_sub_flags: assert property (
    exec && s_reg.cmd.op == cxs_pkg::sub_op |=>
    flags[cxs_pkg::FLG_C] == ($past(rd) < $past(s_reg.src_val)) &&
    flags[cxs_pkg::FLG_Z] == ($past(rd) == $past(s_reg.src_val)))
    else $error("subtract flags wrong");
  a_sub_decimal: assert property (
    exec && s_reg.cmd.op == cxs_pkg::sub_op |=> flags[cxs_pkg::FLG_D])
    else $error("decimal flag not set");
  a_swap_value: assert property (
    exec && s_reg.cmd.op == cxs_pkg::swap_op && rf_req.we |->
    rf_req.wdata == {rd[3:0], rd[7:4]} ##1 flags[cxs_pkg::FLG_S] == $past(rd[3]))
    else $error("swap wrong");
  a_mask_test: assert property (
    exec && s_reg.cmd.op == cxs_pkg::inverted_mask_test_op |->
    !rf_req.we ##1 flags[cxs_pkg::FLG_Z] == ((~$past(rd) & $past(s_reg.src_val)) == 8'h00)
    && !flags[cxs_pkg::FLG_V])
    else $error("mask test wrong");
  a_indirect_addr: assert property (
    s_dst_fetch |-> ##2 rf_req.addr == $past(rd, 2))
    else $error("indirect address not used");

endmodule // cxs_exec

// ==== cxs_rf_model.sv ====
// register file on the far side of the execution block
module cxs_rf_model (
  input wire logic clk, // core clock
  input cxs_pkg::cxs_rf_req_t rf_req, // access from the block
  output logic [7:0] rf_rdata // read data, same cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];

  ////////////////////////////////////////////////////////////////////////
  // combinational read, so indirect addresses resolve in one step
  assign rf_rdata = mem[rf_req.addr];

  always @(posedge clk) begin
    if (rf_req.we) begin
      mem[rf_req.addr] <= rf_req.wdata;
    end
  end
endmodule // cxs_rf_model

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, cmd_valid, cmd_ready, done, rst_pin_n, ext_irq, cpu_en, sys_en, stopped;
  logic [7:0] rf_rdata, flags, ptr0, ptr1, ef, ep0, ep1;
  cxs_pkg::cxs_cmd_t cmd;
  cxs_pkg::cxs_rf_req_t rf_req;
  int n_errors, checked, cyc;
  logic [7:0] n_wait;

  cxs_exec i_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .done(done), .rf_req(rf_req), .rf_rdata(rf_rdata),
    .external_reset_pin_n(rst_pin_n), .ext_irq(ext_irq), .flags(flags),
    .window_pointer_zero(ptr0), .window_pointer_one(ptr1), .cpu_clk_en(cpu_en),
    .sys_clk_en(sys_en), .stopped(stopped));
  cxs_rf_model i_rf (.clk(clk), .rf_req(rf_req), .rf_rdata(rf_rdata));

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] rd(input logic [7:0] a);
    return a == cxs_pkg::PTR0_ADDR ? ep0 : a == cxs_pkg::PTR1_ADDR ? ep1 : i_rf.mem[a];
  endfunction

  // returns expected destination value (unchanged for carry set and mask test) and new flags
  function automatic logic [15:0] model(input cxs_pkg::cxs_op_t op, input logic [7:0] d, s, f);
    logic [7:0] r;
    logic [7:0] g;
    r = d;
    g = f;
    case (op)
      cxs_pkg::carry_set_op: g[cxs_pkg::FLG_C] = 1'b1;
      cxs_pkg::arith_right_shift_op: begin
        r = {d[7], d[7:1]};
        g[cxs_pkg::FLG_C] = d[0];
        g[cxs_pkg::FLG_V] = 1'b0;
      end
      cxs_pkg::sub_op: begin
        r = d - s;
        g[cxs_pkg::FLG_C] = d < s;
        g[cxs_pkg::FLG_V] = (d[7] != s[7]) && (r[7] == s[7]);
        g[cxs_pkg::FLG_D] = 1'b1;
        g[cxs_pkg::FLG_H] = d[3:0] < s[3:0];
      end
      cxs_pkg::swap_op: r = {d[3:0], d[7:4]};
      cxs_pkg::inverted_mask_test_op: begin
        r = ~d & s;
        g[cxs_pkg::FLG_V] = 1'b0;
      end
      default: ;
    endcase
    if (op != cxs_pkg::carry_set_op) begin
      g[cxs_pkg::FLG_Z] = r == 8'h00;
      g[cxs_pkg::FLG_S] = r[7];
    end
    if (op == cxs_pkg::inverted_mask_test_op) r = d;
    return {r, g};
  endfunction

  task automatic issue(input cxs_pkg::cxs_op_t op, input logic di, si, im, w,
                       input logic [7:0] d, s);
    @(negedge clk);
    cmd = '{op, di, si, im, w, d, s};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic wait_done();
    n_wait = 8'h00;
    while (n_wait < 8'h0c && done !== 1'b1) begin
      @(negedge clk);
      n_wait++;
    end
    chk("done", 8'h01, {7'h00, done});
  endtask

  task automatic run(input cxs_pkg::cxs_op_t op, input logic di, si, im, w,
                     input logic [7:0] d, s, input logic [7:0] fm);
    logic [7:0] da, sv, keep;
    logic [15:0] e;
    da = di ? rd(d) : d;
    sv = im ? s : rd(si ? rd(s) : s);
    keep = rd(s);
    e = model(op, rd(da), sv, ef);
    issue(op, di, si, im, w, d, s);
    wait_done();
    if (op == cxs_pkg::carry_set_op) chk("cycles", {5'h00, cxs_pkg::CYC_SHORT}, n_wait);
    chk("result", e[15:8], rd(da));
    chk("flags", e[7:0] & fm, flags & fm);
    if (!im && s != da) chk("source", keep, rd(s));
    chk("pointer0", ep0, ptr0);
    ef = (e[7:0] & fm) | (flags & ~fm);
  endtask

  task automatic ptr_load(input logic [7:0] s);
    case (s[1:0])
      2'b10: ep0 = {s[7:3], ep0[2:0]};
      2'b01: ep1 = {s[7:3], ep1[2:0]};
      2'b00: begin
        ep0 = {s[7:4], 1'b0, ep0[2:0]};
        ep1 = {s[7:4], 1'b1, ep1[2:0]};
      end
      default: ;
    endcase
    issue(cxs_pkg::pointer_load_op, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, s);
    wait_done();
    chk("pointer0", ep0, ptr0);
    chk("pointer1", ep1, ptr1);
    chk("flags", ef, flags);
  endtask

  task automatic stop_wake(input logic by_pin);
    issue(cxs_pkg::stop_op, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 10 && stopped !== 1'b1; i++) @(negedge clk);
    chk("clock enables", 8'h00, {6'h00, cpu_en, sys_en});
    repeat (20) @(negedge clk);
    chk("stopped", 8'h01, {7'h00, stopped});
    if (by_pin) rst_pin_n = 1'b0;
    else ext_irq = 1'b1;
    wait_done();
    repeat (16) @(negedge clk);
    rst_pin_n = 1'b1;
    ext_irq = 1'b0;
    chk("awake", 8'h07, {5'h00, cpu_en, sys_en, ~stopped});
    chk("flags", ef, flags);
    chk("pointer1", ep1, ptr1);
    chk("pointer0", ep0, ptr0);
    repeat (3) begin
      issue(cxs_pkg::idle_op, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      wait_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {srst, cmd_valid, rst_pin_n, ext_irq} = 4'ha;
    cmd = '0;
    {ef, ep0, ep1, n_errors, checked, cyc} = '0;
    {i_rf.mem[0], i_rf.mem[1], i_rf.mem[2], i_rf.mem[3]} = 32'h9a_21_03_bc;
    {i_rf.mem[4], i_rf.mem[5], i_rf.mem[6]} = 24'hc7_02_2b;
    {i_rf.mem[16], i_rf.mem[17], i_rf.mem[18], i_rf.mem[19]} = 32'hff_3e_80_80;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk("after reset", 8'h07, {5'h00, cmd_ready, cpu_en, sys_en});
    chk("flags", cxs_pkg::FLAGS_RST, flags);
    chk("pointer0", cxs_pkg::PTR0_RST, ptr0);
    run(cxs_pkg::sub_op, 0, 0, 0, 0, 8'h01, 8'h02, 8'hff);
    run(cxs_pkg::sub_op, 0, 1, 0, 1, 8'h01, 8'h02, 8'hff);
    run(cxs_pkg::sub_op, 0, 0, 1, 1, 8'h01, 8'h90, 8'hff);
    run(cxs_pkg::sub_op, 0, 0, 1, 1, 8'h12, 8'h80, 8'hff);
    run(cxs_pkg::sub_op, 0, 0, 1, 1, 8'h13, 8'h01, 8'hff);
    run(cxs_pkg::carry_set_op, 0, 0, 0, 0, 8'h00, 8'h00, 8'hff);
    run(cxs_pkg::arith_right_shift_op, 0, 0, 0, 0, 8'h00, 8'h00, 8'hff);
    run(cxs_pkg::arith_right_shift_op, 1, 0, 0, 0, 8'h02, 8'h02, 8'hff);
    run(cxs_pkg::swap_op, 0, 0, 0, 0, 8'h11, 8'h11, 8'h6f);
    run(cxs_pkg::inverted_mask_test_op, 0, 0, 0, 0, 8'h04, 8'h05, 8'hff);
    run(cxs_pkg::inverted_mask_test_op, 0, 0, 1, 1, 8'h06, 8'hc4, 8'hff);
    run(cxs_pkg::inverted_mask_test_op, 0, 1, 0, 1, 8'h04, 8'h05, 8'hff);
    ptr_load(8'h40);
    ptr_load(8'h52);
    ptr_load(8'h69);
    ptr_load(8'h7b);
    run(cxs_pkg::sub_op, 0, 0, 0, 0, 8'h10, 8'hd6, 8'hff);
    stop_wake(1'b0);
    stop_wake(1'b1);
    stop_test();
  end
endmodule // testbench
